//--- design/sgoc_regs.svh
// Register offsets, reset values and timing constants of the object control block
`ifndef SGOC_REGS_SVH
`define SGOC_REGS_SVH
`define SGOC_A_CONN 4'h0
`define SGOC_A_MISC 4'h1
`define SGOC_A_BLK 4'h1
`define SGOC_A_PLEN 4'h2
`define SGOC_A_STAT 4'h3
`define SGOC_R_LATCH 4'h0
`define SGOC_R_CTRL 4'h1
`define SGOC_R_REL_PNL 4'h2
`define SGOC_R_REL_LNK 4'h3
`define SGOC_R_CMD_PNL 4'h4
`define SGOC_R_CMD_LNK 4'h5
`define SGOC_R_BLK0 4'h8
`define SGOC_R_CTIM0 4'h8
`define SGOC_R_ST_OUT 4'h0
`define SGOC_R_ST_POS 4'h1
`define SGOC_R_ST_FAIL 4'h2
`define SGOC_OP_DIRECT 2'h0
`define SGOC_OP_SELECT 2'h1
`define SGOC_OP_EXEC 2'h2
`define SGOC_POS_OPEN 2'h1
`define SGOC_POS_CLOSE 2'h2
`define SGOC_NCTL 3'h6
`define SGOC_TIME_RST 20'h003E8
`define SGOC_TICK_NS 1000000
`define SGOC_CLK_NS 10
`endif

//--- design/sgoc_pkg.sv
// Types shared by the object control block
package sgoc_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_PULSE, PH_READY} sgoc_phase_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sgoc_bus_t;
  typedef struct packed {
    logic [15:0][15:0] conn;
    logic [15:0] latch_cfg;
    logic [15:0] latch_q;
    logic [15:0] out;
    logic [3:0][15:0] blkm;
    logic [3:0] blk;
    logic rmt_pnl;
    logic lr_use_di;
    logic lr_di;
    logic rel_use_di;
    logic rel_di;
    logic rmt;
    logic [7:0] rdy_en;
    logic [7:0][19:0] plen;
    logic [5:0][19:0] ctim;
    logic [7:0][19:0] cnt;
    sgoc_phase_t [7:0] ph;
    logic [7:0] dir;
    logic [7:0] fail;
    logic [7:0] evt;
    logic [15:0] pos;
    logic [5:0] ro_p;
    logic [5:0] rc_p;
    logic [5:0] lo_p;
    logic [5:0] lc_p;
    logic sel_v;
    logic [2:0] sel_obj;
    logic sel_dir;
    logic [16:0] tick_cnt;
    logic [31:0] rdata;
    logic [5:0] op;
    logic [5:0] cl;
  } sgoc_state_t;
endpackage : sgoc_pkg

//--- design/sgoc_top.sv
// Output matrix, blocking matrix and switchgear object control
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "sgoc_regs.svh"
// Function
// R1: Non-latched output follows OR of its signals
// R2: Latched output holds until latch release
// R3: One release clears all latched outputs
// R4: Release from discrete input, keypad or link
// R5: Any internal signal connects to any target
// R6: Blocking source active suppresses selected stage
// R7: Objects 1-6 controllable, 7-8 status only
// R8: Two-bit position; 00 and 11 undefined
// R9: Command pulse length configurable per object
// R10: No new position in time: failure, event
// R11: Completion timeout supervises ready input only
// R12: Separate open and close pulse outputs
// R13: Read-only object timeout: failure and event
// R14: Local/remote mode gates local/remote inputs
// R15: Control inputs act on rising edge
// R16: Drivers hold command inputs 60 ms
// R17: Local mode: panel accepted, link rejected
// R18: Remote mode: link accepted, panel rejected
// R19: Mode from panel or one discrete input
// R20: Link commands need no password
// R21: Execute needs matching prior select
// R22: Timers use ms tick, restart per command
module sgoc_top #(
  parameter int MS_CYC = `SGOC_TICK_NS / `SGOC_CLK_NS
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Register port
  input wire sgoc_pkg::sgoc_bus_t bus_i,
  output logic [31:0] rdata_o,
  // Internal signal sources
  input wire logic [1:0] discrete_input_i,
  input wire logic [3:0] stage_start_i,
  input wire logic [3:0] stage_trip_i,
  input wire logic [3:0] logic_out_i,
  // Object contacts
  input wire logic [7:0] pos_open_i,
  input wire logic [7:0] pos_close_i,
  input wire logic [5:0] obj_ready_i,
  // Assigned control inputs
  input wire logic [5:0] rem_open_i,
  input wire logic [5:0] rem_close_i,
  input wire logic [5:0] loc_open_i,
  input wire logic [5:0] loc_close_i,
  // Matrix targets and objects
  output logic [15:0] targets_o,
  output logic [3:0] stage_block_o,
  output logic [5:0] obj_open_o,
  output logic [5:0] obj_close_o,
  output logic [15:0] obj_state_o,
  output logic [7:0] obj_fail_o,
  output logic [7:0] undef_event_o,
  output logic remote_o
);
  sgoc_pkg::sgoc_state_t q;
  sgoc_pkg::sgoc_state_t next_q;
  logic [15:0] sig;
  logic [15:0] drive;
  logic tick;
  logic rel;
  logic mode;
  logic [5:0] op_req;
  logic [5:0] cl_req;
  logic [5:0] lnk_go;
  logic [5:0] pnl_go;
  logic [5:0] ro_go;
  logic [1:0] dec_pos;
  logic [3:0] a_hi;
  logic [3:0] a_lo;
  logic lnk_wr;
  logic pnl_wr;
  logic sel_hit;

  // ==========================================================
  // Matrices and command sources
  always_comb
  begin
    a_hi = bus_i.addr[7:4];
    a_lo = bus_i.addr[3:0];
    sig = {|q.op, |q.fail, logic_out_i, stage_trip_i, stage_start_i, discrete_input_i};
    for (int t = 0; t < 16; t++)
    begin
      drive[t] = |(sig & q.conn[t]); // R5
    end
    tick = (q.tick_cnt == 17'(MS_CYC - 1)); // R22
    mode = q.lr_use_di ? discrete_input_i[q.lr_di] : q.rmt_pnl; // R19
    rel = (bus_i.wr && a_hi == `SGOC_A_MISC &&
      (a_lo == `SGOC_R_REL_PNL || a_lo == `SGOC_R_REL_LNK)) ||
      (q.rel_use_di && discrete_input_i[q.rel_di]); // R4
    pnl_wr = bus_i.wr && a_hi == `SGOC_A_MISC && a_lo == `SGOC_R_CMD_PNL;
    lnk_wr = bus_i.wr && a_hi == `SGOC_A_MISC && a_lo == `SGOC_R_CMD_LNK;
    sel_hit = q.sel_v && q.sel_obj == bus_i.wdata[2:0] && q.sel_dir == bus_i.wdata[3];
    pnl_go = '0;
    lnk_go = '0;
    if (bus_i.wdata[2:0] < `SGOC_NCTL)
    begin
      pnl_go[bus_i.wdata[2:0]] = pnl_wr && !mode; // R17 R18
      // No password stage on link commands
      lnk_go[bus_i.wdata[2:0]] = lnk_wr && mode &&
        (bus_i.wdata[5:4] == `SGOC_OP_DIRECT ||
        (bus_i.wdata[5:4] == `SGOC_OP_EXEC && sel_hit)); // R18 R20 R21
    end
    ro_go = rem_open_i & ~q.ro_p & {6{mode}}; // R14 R15
    op_req = ro_go | (loc_open_i & ~q.lo_p & {6{!mode}}) |
      ((pnl_go | lnk_go) & {6{!bus_i.wdata[3]}}); // R12 R14 R15
    cl_req = ~op_req & ((rem_close_i & ~q.rc_p & {6{mode}}) |
      (loc_close_i & ~q.lc_p & {6{!mode}}) |
      ((pnl_go | lnk_go) & {6{bus_i.wdata[3]}})); // R12 R14 R15
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    next_q = q;
    next_q.tick_cnt = tick ? '0 : q.tick_cnt + 17'h00001;
    next_q.latch_q = (q.latch_q & ~{16{rel}}) | (drive & q.latch_cfg); // R2 R3
    next_q.out = drive | next_q.latch_q; // R1 R2
    for (int s = 0; s < 4; s++)
    begin
      next_q.blk[s] = |(sig & q.blkm[s]); // R6
    end
    next_q.rmt = mode;
    next_q.ro_p = rem_open_i;
    next_q.rc_p = rem_close_i;
    next_q.lo_p = loc_open_i;
    next_q.lc_p = loc_close_i;
    next_q.evt = '0;
    next_q.rdata = '0;
    next_q.pos = {pos_close_i[7], pos_open_i[7], pos_close_i[6], pos_open_i[6],
      pos_close_i[5], pos_open_i[5], pos_close_i[4], pos_open_i[4],
      pos_close_i[3], pos_open_i[3], pos_close_i[2], pos_open_i[2],
      pos_close_i[1], pos_open_i[1], pos_close_i[0], pos_open_i[0]}; // R8
    if (lnk_wr && mode)
    begin
      // Any link command written in remote mode other than a select drops the pending select
      next_q.sel_v = (bus_i.wdata[5:4] == `SGOC_OP_SELECT); // R21
      next_q.sel_obj = bus_i.wdata[2:0];
      next_q.sel_dir = bus_i.wdata[3];
    end
    // Register writes
    if (bus_i.wr)
    begin
      if (a_hi == `SGOC_A_CONN)
      begin
        next_q.conn[a_lo] = bus_i.wdata[15:0];
      end
      else if (a_hi == `SGOC_A_MISC && a_lo == `SGOC_R_LATCH)
      begin
        next_q.latch_cfg = bus_i.wdata[15:0];
      end
      else if (a_hi == `SGOC_A_MISC && a_lo == `SGOC_R_CTRL)
      begin
        {next_q.rdy_en, next_q.rel_di, next_q.rel_use_di} = bus_i.wdata[15:6];
        {next_q.lr_di, next_q.lr_use_di, next_q.rmt_pnl} = bus_i.wdata[2:0];
      end
      else if (a_hi == `SGOC_A_BLK && a_lo[3] && !a_lo[2])
      begin
        next_q.blkm[a_lo[1:0]] = bus_i.wdata[15:0];
      end
      else if (a_hi == `SGOC_A_PLEN && !a_lo[3])
      begin
        next_q.plen[a_lo[2:0]] = bus_i.wdata[19:0]; // R9 R13
      end
      else if (a_hi == `SGOC_A_PLEN && a_lo[2:0] < `SGOC_NCTL)
      begin
        next_q.ctim[a_lo[2:0]] = bus_i.wdata[19:0]; // R11
      end
    end
    // Register reads
    if (bus_i.rd)
    begin
      if (a_hi == `SGOC_A_CONN)
      begin
        next_q.rdata = {16'h0000, q.conn[a_lo]};
      end
      else if (a_hi == `SGOC_A_MISC && a_lo == `SGOC_R_LATCH)
      begin
        next_q.rdata = {16'h0000, q.latch_cfg};
      end
      else if (a_hi == `SGOC_A_MISC && a_lo == `SGOC_R_CTRL)
      begin
        next_q.rdata = {16'h0000, q.rdy_en, q.rel_di, q.rel_use_di, 3'h0,
          q.lr_di, q.lr_use_di, q.rmt_pnl};
      end
      else if (a_hi == `SGOC_A_BLK && a_lo[3] && !a_lo[2])
      begin
        next_q.rdata = {16'h0000, q.blkm[a_lo[1:0]]};
      end
      else if (a_hi == `SGOC_A_PLEN && !a_lo[3])
      begin
        next_q.rdata = {12'h000, q.plen[a_lo[2:0]]};
      end
      else if (a_hi == `SGOC_A_PLEN && a_lo[2:0] < `SGOC_NCTL)
      begin
        next_q.rdata = {12'h000, q.ctim[a_lo[2:0]]};
      end
      else if (a_hi == `SGOC_A_STAT && a_lo == `SGOC_R_ST_OUT)
      begin
        next_q.rdata = {16'h0000, q.out};
      end
      else if (a_hi == `SGOC_A_STAT && a_lo == `SGOC_R_ST_POS)
      begin
        next_q.rdata = {16'h0000, q.pos};
      end
      else if (a_hi == `SGOC_A_STAT && a_lo == `SGOC_R_ST_FAIL)
      begin
        next_q.rdata = {23'h000000, q.rmt, q.fail};
      end
    end
    // Object supervision
    for (int i = 0; i < 6; i++)
    begin
      dec_pos = q.pos[2*i +: 2];
      if (op_req[i] || cl_req[i])
      begin
        next_q.ph[i] = sgoc_pkg::PH_PULSE; // R22
        next_q.dir[i] = cl_req[i];
        next_q.cnt[i] = '0;
        next_q.fail[i] = 1'b0;
      end
      else
      begin
        case (q.ph[i])
          sgoc_pkg::PH_PULSE:
          begin
            if (dec_pos == (q.dir[i] ? `SGOC_POS_CLOSE : `SGOC_POS_OPEN))
            begin
              next_q.ph[i] = q.rdy_en[i] ? sgoc_pkg::PH_READY : sgoc_pkg::PH_IDLE; // R11
              next_q.cnt[i] = '0;
            end
            else if (tick)
            begin
              next_q.cnt[i] = q.cnt[i] + 20'h00001;
              if (q.cnt[i] + 20'h00001 >= q.plen[i])
              begin
                next_q.fail[i] = 1'b1; // R10
                next_q.evt[i] = 1'b1; // R10
                next_q.ph[i] = sgoc_pkg::PH_IDLE; // R9
              end
            end
          end
          sgoc_pkg::PH_READY:
          begin
            if (obj_ready_i[i])
            begin
              next_q.ph[i] = sgoc_pkg::PH_IDLE;
            end
            else if (tick)
            begin
              next_q.cnt[i] = q.cnt[i] + 20'h00001;
              if (q.cnt[i] + 20'h00001 >= q.ctim[i])
              begin
                next_q.fail[i] = 1'b1; // R11
                next_q.ph[i] = sgoc_pkg::PH_IDLE;
              end
            end
          end
          default:
          begin
            next_q.ph[i] = sgoc_pkg::PH_IDLE;
          end
        endcase
      end
    end
    // Status-only objects: supervise time spent undefined
    for (int i = 6; i < 8; i++)
    begin
      dec_pos = q.pos[2*i +: 2];
      if (dec_pos == `SGOC_POS_OPEN || dec_pos == `SGOC_POS_CLOSE)
      begin
        next_q.ph[i] = sgoc_pkg::PH_IDLE; // R7 R8
        next_q.fail[i] = 1'b0;
        next_q.cnt[i] = '0;
      end
      else if (q.ph[i] == sgoc_pkg::PH_IDLE)
      begin
        next_q.ph[i] = sgoc_pkg::PH_PULSE;
      end
      else if (q.ph[i] == sgoc_pkg::PH_PULSE && tick)
      begin
        next_q.cnt[i] = q.cnt[i] + 20'h00001;
        if (q.cnt[i] + 20'h00001 >= q.plen[i])
        begin
          next_q.fail[i] = 1'b1; // R13
          next_q.evt[i] = 1'b1; // R13
          next_q.ph[i] = sgoc_pkg::PH_READY;
        end
      end
    end
    for (int i = 0; i < 6; i++)
    begin
      next_q.op[i] = next_q.ph[i] == sgoc_pkg::PH_PULSE && !next_q.dir[i]; // R12
      next_q.cl[i] = next_q.ph[i] == sgoc_pkg::PH_PULSE && next_q.dir[i]; // R12
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      q <= '0;
      q.plen <= {8{`SGOC_TIME_RST}};
      q.ctim <= {6{`SGOC_TIME_RST}};
    end
    else
    begin
      q <= next_q;
    end
  end

  assign rdata_o = q.rdata;
  assign targets_o = q.out;
  assign stage_block_o = q.blk;
  assign obj_open_o = q.op;
  assign obj_close_o = q.cl;
  assign obj_state_o = q.pos;
  assign obj_fail_o = q.fail;
  assign undef_event_o = q.evt;
  assign remote_o = q.rmt;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  out_follow_a: assert property (##1 targets_o == ($past(drive) | q.latch_q)) // R1
    else $error("Output does not follow matrix");
  latch_hold_a: assert property (!rel |=> (q.latch_q & $past(q.latch_q)) == $past(q.latch_q)) // R2
    else $error("Latched output dropped");
  latch_release_a: assert property (rel |=> q.latch_q == $past(drive & q.latch_cfg)) // R3
    else $error("Release left a latch set");
  block_out_a: assert property (##1 stage_block_o == {|($past(sig) & $past(q.blkm[3])),
    |($past(sig) & $past(q.blkm[2])), |($past(sig) & $past(q.blkm[1])),
    |($past(sig) & $past(q.blkm[0]))}) // R6
    else $error("Stage blocking wrong");
  open_pulse_a: assert property (op_req[0] |=> obj_open_o[0] && !obj_close_o[0]) // R12
    else $error("Open command gave no pulse");
  pulse_fail_a: assert property (q.ph[0] == sgoc_pkg::PH_PULSE && tick && !op_req[0] &&
    !cl_req[0] && q.pos[1:0] != (q.dir[0] ? `SGOC_POS_CLOSE : `SGOC_POS_OPEN) &&
    q.cnt[0] + 20'h00001 >= q.plen[0] |=> obj_fail_o[0] && undef_event_o[0]) // R10
    else $error("Pulse timeout not reported");
  link_mode_a: assert property (lnk_go != '0 |-> mode) // R18
    else $error("Link command taken in local mode");
  panel_mode_a: assert property (pnl_go != '0 |-> !mode) // R17
    else $error("Panel command taken in remote mode");
  edge_only_a: assert property ((ro_go & $past(rem_open_i)) == '0) // R15
    else $error("Level acted as command");
  exec_select_a: assert property (lnk_wr && bus_i.wdata[5:4] == `SGOC_OP_EXEC && !q.sel_v
    |-> lnk_go == '0) // R21
    else $error("Execute without select acted");
  tick_wrap_a: assert property (tick |=> q.tick_cnt == '0 && !tick) // R22
    else $error("Millisecond tick wrong");
  pos_follow_a: assert property (##1 obj_state_o[1:0] ==
    {$past(pos_close_i[0]), $past(pos_open_i[0])}) // R8
    else $error("Position state wrong");
  fail_event_a: assert property ($rose(obj_fail_o[5]) &&
    $past(q.ph[5]) == sgoc_pkg::PH_PULSE |-> undef_event_o[5]) // R10
    else $error("Pulse failure without event");

  release_c: cover property (q.latch_q != '0 ##1 rel ##1 q.latch_q == '0);
  fail_c: cover property (obj_open_o[0] ##[1:1000] undef_event_o[0]);
  sbo_c: cover property (q.sel_v ##1 lnk_go != '0);
  ready_c: cover property (q.ph[1] == sgoc_pkg::PH_READY ##1 q.ph[1] == sgoc_pkg::PH_IDLE);
endmodule : sgoc_top
`default_nettype wire

//--- testbench/sgoc_breaker_model.sv
// Behavioural switchgear objects answering open and close pulses
`timescale 1ns/10ps
`default_nettype none
module sgoc_breaker_model #(
  parameter int DLY = 5
) (
  // Clock and faults
  input wire logic mclk_i,
  input wire logic [5:0] stuck_i,
  // Command pulses
  input wire logic [5:0] open_cmd_i,
  input wire logic [5:0] close_cmd_i,
  // Contacts
  output logic [7:0] pos_open_o,
  output logic [7:0] pos_close_o,
  output logic [5:0] ready_o
);
  int cnt [6];
  // Ready once no command pulse is pending
  assign ready_o = ~(open_cmd_i | close_cmd_i);
  initial
  begin
    pos_open_o = 8'hC0;
    pos_close_o = 8'h00;
    for (int i = 0; i < 6; i++) cnt[i] = 0;
  end
  // Travel leaves both contacts low until the end position
  always @(posedge mclk_i)
  begin
    for (int i = 0; i < 6; i++)
    begin
      if ((open_cmd_i[i] | close_cmd_i[i]) && !stuck_i[i])
      begin
        cnt[i] <= cnt[i] + 1;
        if (cnt[i] == 0)
        begin
          pos_open_o[i] <= 1'b0;
          pos_close_o[i] <= 1'b0;
        end
        if (cnt[i] == DLY)
        begin
          pos_open_o[i] <= open_cmd_i[i];
          pos_close_o[i] <= !open_cmd_i[i];
        end
      end
      else
        cnt[i] <= 0;
    end
  end
endmodule : sgoc_breaker_model
`default_nettype wire

//--- testbench/tb_switchgear_object_control.sv
// Self-checking bench of the object control block
`timescale 1ns/10ps
`default_nettype none
module tb_switchgear_object_control;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  sgoc_pkg::sgoc_bus_t bus_i = '0;
  logic [31:0] rdata_o;
  logic [1:0] discrete_input_i = 2'h0;
  logic [3:0] stage_start_i = 4'h0;
  logic [3:0] stage_trip_i = 4'h0;
  logic [7:0] pos_open_i;
  logic [7:0] pos_close_i;
  logic [5:0] obj_ready_i;
  logic [5:0] rem_open_i = 6'h00;
  logic [5:0] rem_close_i = 6'h00;
  logic [5:0] loc_open_i = 6'h00;
  logic [5:0] loc_close_i = 6'h00;
  logic [5:0] stuck = 6'h20;
  logic [15:0] targets_o;
  logic [3:0] stage_block_o;
  logic [5:0] obj_open_o;
  logic [5:0] obj_close_o;
  logic [15:0] obj_state_o;
  logic [7:0] obj_fail_o;
  logic [7:0] undef_event_o;
  logic remote_o;
  logic [31:0] rd_val;
  logic ev_seen = 1'b0;
  int err_count = 0;
  int checked = 0;
  always #5 mclk_i = !mclk_i;
  sgoc_top #(.MS_CYC(10)) uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .discrete_input_i(discrete_input_i), .stage_start_i(stage_start_i),
    .stage_trip_i(stage_trip_i), .logic_out_i(4'h0), .pos_open_i(pos_open_i),
    .pos_close_i(pos_close_i), .obj_ready_i(obj_ready_i), .rem_open_i(rem_open_i),
    .rem_close_i(rem_close_i), .loc_open_i(loc_open_i), .loc_close_i(loc_close_i),
    .targets_o(targets_o), .stage_block_o(stage_block_o), .obj_open_o(obj_open_o),
    .obj_close_o(obj_close_o), .obj_state_o(obj_state_o), .obj_fail_o(obj_fail_o),
    .undef_event_o(undef_event_o), .remote_o(remote_o));
  sgoc_breaker_model #(.DLY(5)) brk (.mclk_i(mclk_i), .stuck_i(stuck),
    .open_cmd_i(obj_open_o), .close_cmd_i(obj_close_o), .pos_open_o(pos_open_i),
    .pos_close_o(pos_close_i), .ready_o(obj_ready_i));
  // ==========================================
  // Bus tasks and comparison
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    // Strobe is dropped by the next call, so writes may run back to back
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    bus_i <= '0;
    #1;
    rd_val = rdata_o;
    @(posedge mclk_i);
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    bus_i <= '0;
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : idle
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // ==========================================
  // Watchdog
  initial
  begin
    // Tests need about 780 cycles
    repeat (2000) @(posedge mclk_i);
    err_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    complete_run();
  end
  // ==========================================
  // Tests
  initial
  begin
    repeat (3) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(posedge mclk_i);
    rd(8'h30);
    chk(rd_val, 32'h0, "outputs after reset");
    $display("test reset done");
    // Plain and latched targets
    wr(8'h00, 32'h0001);
    wr(8'h01, 32'h0004);
    wr(8'h10, 32'h0002);
    discrete_input_i <= 2'h1;
    stage_start_i <= 4'h1;
    idle(3);
    chk(targets_o[1:0], 2'h3, "targets set");
    discrete_input_i <= 2'h0;
    stage_start_i <= 4'h0;
    idle(3);
    chk(targets_o[1:0], 2'h2, "plain drops, latched holds");
    wr(8'h12, 32'h1);
    idle(3);
    chk(targets_o[1:0], 2'h0, "keypad release");
    $display("test matrix done");
    // Blocking
    wr(8'h18, 32'h0040);
    stage_trip_i <= 4'h1;
    idle(3);
    chk(stage_block_o, 4'h1, "stage blocked");
    stage_trip_i <= 4'h0;
    idle(3);
    chk(stage_block_o, 4'h0, "block released");
    $display("test block done");
    // Local mode: panel accepted, link refused
    wr(8'h14, 32'h00);
    idle(1);
    chk({31'h0, obj_open_o[0]}, 32'h1, "open pulse obj0");
    wr(8'h15, 32'h04);
    idle(30);
    chk(obj_state_o[1:0], 2'h1, "panel open obj0");
    chk(obj_state_o[9:8], 2'h0, "link ignored local");
    chk(obj_state_o[13:12], 2'h1, "status obj6");
    $display("test local done");
    // Remote mode: link accepted, panel refused, select needed
    wr(8'h11, 32'h1);
    wr(8'h14, 32'h03);
    wr(8'h15, 32'h22);
    wr(8'h15, 32'h19);
    wr(8'h15, 32'h29);
    idle(30);
    chk({31'h0, remote_o}, 32'h1, "remote mode");
    chk(obj_state_o[7:6], 2'h0, "panel ignored remote");
    chk(obj_state_o[5:4], 2'h0, "execute without select");
    chk(obj_state_o[3:2], 2'h2, "select execute close");
    $display("test remote done");
    // Control inputs act on edges only
    rem_open_i <= 6'h02;
    idle(30);
    chk(obj_state_o[3:2], 2'h1, "edge opens obj1");
    wr(8'h15, 32'h09);
    idle(600);
    chk(obj_state_o[3:2], 2'h2, "held level no reopen");
    rem_open_i <= 6'h00;
    loc_open_i <= 6'h08;
    idle(30);
    chk(obj_state_o[7:6], 2'h0, "local input ignored");
    $display("test inputs done");
    // Stuck object fails after pulse length
    wr(8'h11, 32'h0);
    wr(8'h25, 32'h2);
    wr(8'h14, 32'h0D);
    idle(5);
    chk({31'h0, obj_fail_o[5]}, 32'h0, "no early fail");
    fork
      idle(60);
      begin
        @(posedge undef_event_o[5]);
        ev_seen = 1'b1;
      end
    join_any
    disable fork;
    idle(2);
    chk({31'h0, obj_fail_o[5]}, 32'h1, "object failed");
    chk({31'h0, obj_close_o[5]}, 32'h0, "pulse ended");
    rd(8'h32);
    chk(rd_val[5], 1'b1, "fail status");
    chk({31'h0, ev_seen}, 32'h1, "event seen");
    $display("test fail done");
    complete_run();
  end
endmodule : tb_switchgear_object_control
`default_nettype wire
